// *** hw/cfg_link_host.sv ***
// controller end: serial master that issues register accesses
// Function
// - link timed by master clock, sensor crosses domains
// - master pulls select low to start access
// - nine address bits, sixteen data bits
// - address msb first, one clock after select
// - sensor samples rising, master changes falling
// - tenth bit high writes, low reads
// - write data follows, msb first, gets stored
// - read returns addressed register, msb first
// - master samples read data on falling edges
// - sensor output released unless returning data
// - wait one clock after last bit, deselect
// - serial clock below input clock fraction limits
// - serial clock at most ten megahertz nominal
// - deselect and idle two clocks between accesses
`default_nettype none
`include "cfg_link_cfg.svh"

module cfg_link_host #(
    parameter int unsigned HALF_CYC = `LINK_HALF_CYC,
    parameter int unsigned LEAD_TICKS = `LINK_LEAD_TICKS,
    parameter int unsigned TAIL_TICKS = `LINK_TAIL_TICKS,
    parameter int unsigned GAP_TICKS = `LINK_GAP_TICKS
) (
    // system side
    input wire logic sys_clk,
    input wire logic rst_b,
    // link
    cfg_link_if.master link,
    // access request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire cfg_link_pkg::addr_t req_addr,
    input wire cfg_link_pkg::data_t req_wdata,
    // access completion
    output logic rsp_valid,
    output var cfg_link_pkg::data_t rsp_rdata
);
    import cfg_link_pkg::*;

    // ------------------------------------------------------------
    // derived counts
    // ------------------------------------------------------------
    // one tick is half a serial clock period
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
    localparam logic [3:0] LEAD_LAST = 4'(LEAD_TICKS - 1);
    localparam logic [3:0] TAIL_LAST = 4'(TAIL_TICKS - 1);
    localparam logic [3:0] GAP_LAST = 4'(GAP_TICKS - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    host_state_e state_r;
    logic [7:0] half_r;
    logic [3:0] tick_r;
    bit_idx_t bit_r;
    logic tick;
    logic rise_tick;
    logic fall_tick;
    logic sck_r;
    logic cs_b_r;
    frame_t tx_sr_r;
    data_t rd_sr_r;
    logic miso_s1_r;
    logic miso_s2_r;
    logic lead_done;
    logic tail_done;
    logic gap_done;
    logic last_fall;

    // ------------------------------------------------------------
    // tick generation
    // ------------------------------------------------------------
    // divider from the system clock; keeps sck at or below the
    // nominal limit for a 100 MHz system clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            half_r <= 8'h00;
        end else if (state_r == ST_IDLE || tick) begin
            half_r <= 8'h00;
        end else begin
            half_r <= half_r + 8'h01;
        end
    end

    assign tick = (state_r != ST_IDLE) && (half_r == HALF_LAST);
    assign rise_tick = tick && (state_r == ST_SHIFT) && !sck_r;
    assign fall_tick = tick && (state_r == ST_SHIFT) && sck_r;
    assign lead_done = tick && (state_r == ST_LEAD) &&
                       (tick_r == LEAD_LAST);
    assign tail_done = tick && (state_r == ST_TAIL) &&
                       (tick_r == TAIL_LAST);
    assign gap_done = tick && (state_r == ST_GAP) &&
                      (tick_r == GAP_LAST);
    assign last_fall = fall_tick && (bit_r == `LINK_LAST_BIT);

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // main access sequence
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (req_valid) begin
                        state_r <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (lead_done) begin
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (last_fall) begin
                        state_r <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    if (tail_done) begin
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (gap_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // tick count inside the lead, tail and gap phases
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_r <= 4'h0;
        end else if (state_r == ST_IDLE || lead_done || last_fall ||
                     tail_done || gap_done) begin
            tick_r <= 4'h0;
        end else if (tick) begin
            tick_r <= tick_r + 4'h1;
        end
    end

    // bit index, advanced after each falling edge but the last
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_r <= 5'h00;
        end else if (state_r == ST_IDLE) begin
            bit_r <= 5'h00;
        end else if (fall_tick && !last_fall) begin
            bit_r <= bit_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // link pins
    // ------------------------------------------------------------
    // select low from request until one period after the last bit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_b_r <= 1'h1;
        end else if (state_r == ST_IDLE && req_valid) begin
            cs_b_r <= 1'h0;
        end else if (tail_done) begin
            cs_b_r <= 1'h1;
        end
    end

    // serial clock idles low, so the first edge in a frame is a rise
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_r <= 1'h0;
        end else if (rise_tick) begin
            sck_r <= 1'h1;
        end else if (fall_tick) begin
            sck_r <= 1'h0;
        end
    end

    // frame word: address, type bit, data; moved on falling edges
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sr_r <= '0;
        end else if (state_r == ST_IDLE && req_valid) begin
            tx_sr_r <= {req_addr, req_write,
                        req_write ? req_wdata : `LINK_REG_RST};
        end else if (fall_tick) begin
            tx_sr_r <= {tx_sr_r[`LINK_FRAME_W-2:0], 1'h0};
        end
    end

    assign link.sck = sck_r;
    assign link.cs_b = cs_b_r;
    assign link.mosi = tx_sr_r[`LINK_FRAME_W-1];

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // pin synchroniser; the sensor changes the line half a period
    // before our sample, which covers the two-cycle delay here
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            miso_s1_r <= 1'h0;
            miso_s2_r <= 1'h0;
        end else begin
            miso_s1_r <= link.miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    // capture on falling edges during the data phase
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_sr_r <= `LINK_REG_RST;
        end else if (state_r == ST_IDLE) begin
            rd_sr_r <= `LINK_REG_RST;
        end else if (fall_tick && bit_r >= `LINK_DATA_IDX &&
                     tx_sr_r[`LINK_FRAME_W-1] == 1'h0 &&
                     state_r == ST_SHIFT) begin
            rd_sr_r <= {rd_sr_r[14:0], miso_s2_r};
        end
    end

    // ------------------------------------------------------------
    // user side
    // ------------------------------------------------------------
    // completion is given only after the gap, so back-to-back
    // requests keep the spacing without further checks
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid <= 1'h0;
            rsp_rdata <= `LINK_REG_RST;
        end else begin
            rsp_valid <= gap_done;
            if (gap_done) begin
                rsp_rdata <= rd_sr_r;
            end
        end
    end

    assign req_ready = (state_r == ST_IDLE);
endmodule

`default_nettype wire

// *** hw/cfg_link_cfg.svh ***
// constants of the configuration serial link
`ifndef CFG_LINK_CFG_SVH
`define CFG_LINK_CFG_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define LINK_ADDR_W 9
`define LINK_DATA_W 16
`define LINK_FRAME_W 26
`define LINK_TYPE_IDX 5'h09
`define LINK_DATA_IDX 5'h0A
`define LINK_LAST_BIT 5'h19
`define LINK_FRAME_BITS 5'h1A
`define LINK_WRITE_CODE 1'h1
`define LINK_REG_RST 16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LINK_SYS_MHZ 100
`define LINK_SCK_MAX_MHZ 10
`define LINK_TSCK_MIN_NS (1000 / `LINK_SCK_MAX_MHZ)
`define LINK_HALF_CYC ((`LINK_TSCK_MIN_NS * `LINK_SYS_MHZ + 1999) / 2000)
`define LINK_LEAD_TICKS 2
`define LINK_TAIL_TICKS 2
`define LINK_GAP_TICKS 4

`endif

// *** hw/cfg_link_pkg.sv ***
// types shared by both ends of the configuration link
`default_nettype none
`include "cfg_link_cfg.svh"

package cfg_link_pkg;
    typedef logic [`LINK_ADDR_W-1:0] addr_t;
    typedef logic [`LINK_DATA_W-1:0] data_t;
    typedef logic [`LINK_FRAME_W-1:0] frame_t;
    typedef logic [4:0] bit_idx_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEAD = 3'b001,
        ST_SHIFT = 3'b010,
        ST_TAIL = 3'b011,
        ST_GAP = 3'b100
    } host_state_e;
endpackage

`default_nettype wire

// *** hw/cfg_link_if.sv ***
// four-wire link between the controller and the sensor
`default_nettype none

interface cfg_link_if;
    logic sck;
    logic cs_b;
    logic mosi;
    logic miso_out;
    logic miso_oe;
    logic miso;

    // a released line is seen as low by the controller
    assign miso = miso_oe & miso_out;

    modport master (
        output sck,
        output cs_b,
        output mosi,
        input miso,
        input miso_oe
    );

    modport sensor (
        input sck,
        input cs_b,
        input mosi,
        output miso_out,
        output miso_oe
    );
endinterface

`default_nettype wire

// *** hw/cfg_link_sensor.sv ***
// sensor end: serial slave plus system-side configuration store
`default_nettype none
`include "cfg_link_cfg.svh"

module cfg_link_sensor #(
    parameter int unsigned REGS = 1 << `LINK_ADDR_W
) (
    // system side
    input wire logic sys_clk,
    input wire logic rst_b,
    // link
    cfg_link_if.sensor link,
    // configuration read port, one cycle latency
    input wire cfg_link_pkg::addr_t cfg_rd_addr,
    output var cfg_link_pkg::data_t cfg_rd_data,
    // write event into the sensor core
    output logic cfg_wr_stb,
    output var cfg_link_pkg::addr_t cfg_wr_addr,
    output var cfg_link_pkg::data_t cfg_wr_data
);
    import cfg_link_pkg::*;

    // ------------------------------------------------------------
    // link domain, clocked by the master's serial clock
    // ------------------------------------------------------------
    logic frame_rst_b;
    bit_idx_t bit_cnt_r;
    logic [`LINK_FRAME_W-2:0] in_sr_r;
    data_t out_sr_r;
    logic oe_r;
    addr_t hold_addr_r;
    data_t hold_data_r;
    logic wr_tgl_r;
    data_t shadow_r [REGS];

    // deselect ends the frame, so no sck edge is needed after it
    assign frame_rst_b = rst_b & ~link.cs_b;

    // bit counter, saturates after the last bit
    always_ff @(posedge link.sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            bit_cnt_r <= 5'h00;
        end else if (bit_cnt_r != `LINK_FRAME_BITS) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // input shift, sampled on rising edges, msb first
    always_ff @(posedge link.sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            in_sr_r <= '0;
        end else if (bit_cnt_r != `LINK_FRAME_BITS) begin
            in_sr_r <= {in_sr_r[`LINK_FRAME_W-3:0], link.mosi};
        end
    end

    // completed write: shadow copy and hold words for the crossing
    // an early deselect never reaches the last bit, so nothing lands
    always_ff @(posedge link.sck or negedge rst_b) begin
        if (!rst_b) begin
            hold_addr_r <= '0;
            hold_data_r <= `LINK_REG_RST;
            wr_tgl_r <= 1'h0;
            for (int i = 0; i < REGS; i++) begin
                shadow_r[i] <= `LINK_REG_RST;
            end
        end else if (bit_cnt_r == `LINK_LAST_BIT &&
                     in_sr_r[15] == `LINK_WRITE_CODE) begin
            hold_addr_r <= in_sr_r[24:16];
            hold_data_r <= {in_sr_r[14:0], link.mosi};
            shadow_r[in_sr_r[24:16]] <= {in_sr_r[14:0], link.mosi};
            wr_tgl_r <= ~wr_tgl_r;
        end
    end

    // read data: loaded at the type bit, driven from the next rise
    // so it is stable across the master's falling-edge sample
    always_ff @(posedge link.sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            out_sr_r <= '0;
            oe_r <= 1'h0;
        end else if (bit_cnt_r == `LINK_TYPE_IDX) begin
            out_sr_r <= shadow_r[in_sr_r[8:0]];
        end else if (bit_cnt_r == `LINK_DATA_IDX) begin
            oe_r <= (in_sr_r[0] != `LINK_WRITE_CODE);
        end else if (oe_r && bit_cnt_r != `LINK_FRAME_BITS) begin
            out_sr_r <= {out_sr_r[14:0], 1'h0};
        end
    end

    assign link.miso_out = out_sr_r[15];
    assign link.miso_oe = oe_r;

    // ------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic wr_evt;
    data_t cfg_mem_r [REGS];

    // toggle crossing; hold words are stable long before the next write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tgl_s1_r <= 1'h0;
            tgl_s2_r <= 1'h0;
            tgl_s3_r <= 1'h0;
        end else begin
            tgl_s1_r <= wr_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    assign wr_evt = tgl_s2_r ^ tgl_s3_r;

    // write event out to the core
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_wr_stb <= 1'h0;
            cfg_wr_addr <= '0;
            cfg_wr_data <= `LINK_REG_RST;
        end else begin
            cfg_wr_stb <= wr_evt;
            if (wr_evt) begin
                cfg_wr_addr <= hold_addr_r;
                cfg_wr_data <= hold_data_r;
            end
        end
    end

    // configuration store seen by the core
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rd_data <= `LINK_REG_RST;
            for (int i = 0; i < REGS; i++) begin
                cfg_mem_r[i] <= `LINK_REG_RST;
            end
        end else begin
            cfg_rd_data <= cfg_mem_r[cfg_rd_addr];
            if (wr_evt) begin
                cfg_mem_r[hold_addr_r] <= hold_data_r;
            end
        end
    end
endmodule

`default_nettype wire

// *** test/cfg_link_monitor.sv ***
// concurrent checks on the serial link between controller and sensor
`default_nettype none

module cfg_link_monitor (
    // system domain
    input wire logic sys_clk,
    input wire logic rst_b,
    // link
    input wire logic sck,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    logic sck_q_r;
    logic sck_rise;
    logic [4:0] rise_cnt_r;
    logic type_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // frame tracking
    // ----------------------------------------
    assign sck_rise = sck & ~sck_q_r;

    // delayed sck, sampled in the system domain
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_q_r <= 1'b0;
        end else begin
            sck_q_r <= sck;
        end
    end

    // rises seen so far, cleared while deselected
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_cnt_r <= 5'h00;
        end else if (cs_b) begin
            rise_cnt_r <= 5'h00;
        end else if (sck_rise) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    // type bit; idles at write so a stale read enable shows up
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            type_r <= 1'b1;
        end else if (cs_b) begin
            type_r <= 1'b1;
        end else if (sck_rise && rise_cnt_r == 5'h09) begin
            type_r <= mosi;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_oe_released: assert property (cs_b |-> !miso_oe)
        else $error("miso driven while deselected");
    chk_write_quiet: assert property (
        miso_oe |-> !type_r && rise_cnt_r >= 5'h0A)
        else $error("miso driven outside read data");
    chk_oe_at_bit: assert property (
        $rose(miso_oe) |-> rise_cnt_r == 5'h0A && $rose(sck))
        else $error("read data started at wrong bit");
    chk_miso_on_rise: assert property (
        miso_oe && $changed(miso_out) |-> $rose(sck))
        else $error("miso moved away from sck rise");
    chk_mosi_on_fall: assert property (
        !cs_b && !$fell(cs_b) && $changed(mosi) |-> $fell(sck))
        else $error("mosi moved away from sck fall");
    chk_sck_idle: assert property (cs_b |-> !sck)
        else $error("sck active while deselected");
    chk_lead_time: assert property (
        $fell(cs_b) |-> !sck [*8] ##1 !sck [*2])
        else $error("sck started too soon after select");
    chk_half_period: assert property (
        $rose(sck) |-> sck [*5] ##1 !sck)
        else $error("sck high time wrong");
    chk_tail_time: assert property (
        $fell(sck) && rise_cnt_r == 5'h1A |->
        !cs_b [*8] ##1 !cs_b [*2] ##[1:2] cs_b)
        else $error("deselect not one period after last bit");
    chk_frame_bits: assert property (
        $rose(cs_b) |-> rise_cnt_r == 5'h1A)
        else $error("frame length not 26 bits");
    chk_gap_time: assert property (
        $rose(cs_b) |-> cs_b [*8] ##1 cs_b [*8] ##1 cs_b [*4])
        else $error("gap between frames too short");

    // main scenarios
    cov_read: cover property ($rose(miso_oe));
    cov_write: cover property ($rose(cs_b) && type_r);
    cov_miso_high: cover property ($rose(miso));
endmodule

`default_nettype wire

// *** test/test_sensor_config_spi_slave.sv ***
// self-checking bench: controller and sensor joined, plus a driven link
`default_nettype none

module test_sensor_config_spi_slave;
    timeunit 1ns;
    timeprecision 100ps;
    import cfg_link_pkg::*;

    logic sys_clk;
    logic rst_b;
    logic req_valid;
    logic req_ready;
    logic req_write;
    addr_t req_addr;
    data_t req_wdata;
    logic rsp_valid;
    data_t rsp_rdata;
    addr_t rd_addr[2];
    data_t rd_data[2];
    logic wr_stb[2];
    addr_t wr_addr[2];
    data_t wr_data[2];
    logic [25:0] sniff;
    data_t msniff;
    int fail_count;
    int checked;
    int mem[2][512];
    logic [24:0] exp_q[2][$];

    cfg_link_if lk();
    cfg_link_if lk2();

    cfg_link_host u_cfg_link_host (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(lk.master),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));
    cfg_link_sensor u_cfg_link_sensor (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(lk.sensor),
        .cfg_rd_addr(rd_addr[0]), .cfg_rd_data(rd_data[0]),
        .cfg_wr_stb(wr_stb[0]), .cfg_wr_addr(wr_addr[0]),
        .cfg_wr_data(wr_data[0]));
    // second sensor, its link driven by the bench
    cfg_link_sensor u_cfg_link_sensor_2 (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(lk2.sensor),
        .cfg_rd_addr(rd_addr[1]), .cfg_rd_data(rd_data[1]),
        .cfg_wr_stb(wr_stb[1]), .cfg_wr_addr(wr_addr[1]),
        .cfg_wr_data(wr_data[1]));
    cfg_link_monitor u_cfg_link_monitor (
        .sys_clk(sys_clk), .rst_b(rst_b), .sck(lk.sck), .cs_b(lk.cs_b),
        .mosi(lk.mosi), .miso_out(lk.miso_out), .miso_oe(lk.miso_oe),
        .miso(lk.miso));

    // ----------------------------------------
    // clock, sniffers and checks
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // wire capture: mosi on rises, miso on falls
    always @(posedge lk.sck) sniff <= {sniff[24:0], lk.mosi};
    always @(negedge lk.sck) msniff <= {msniff[14:0], lk.miso};

    task automatic cmp(input string what, input data_t exp, input data_t got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic take_stb(input int k);
        logic [24:0] e;
        if (exp_q[k].size() == 0) begin
            cmp("unexpected write strobe", 16'h0000, 16'h0001);
        end else begin
            e = exp_q[k].pop_front();
            cmp("write address", data_t'(e[24:16]), data_t'(wr_addr[k]));
            cmp("write data", e[15:0], wr_data[k]);
        end
    endtask

    // strobe is one cycle wide, so the falling edge sees it once
    always @(negedge sys_clk) begin
        for (int k = 0; k < 2; k++) begin
            if (wr_stb[k] === 1'b1)
                take_stb(k);
        end
    end

    task automatic sync(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic core_rd(input int k, input addr_t a);
        rd_addr[k] = a;
        sync(2);
        cmp("core read", data_t'(mem[k][a]), rd_data[k]);
    endtask

    // one host access; junk pulses a request while busy
    task automatic access(input logic w, input addr_t a, input data_t d,
                          input logic junk);
        int n;
        cmp("ready idle", 16'h0001, data_t'(req_ready));
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        sync(1);
        req_valid = 1'b0;
        if (w)
            exp_q[0].push_back({a, d});
        if (junk) begin
            sync(50);
            cmp("ready busy", 16'h0000, data_t'(req_ready));
            req_valid = 1'b1;
            req_addr = ~a;
            req_wdata = ~d;
            sync(1);
            req_valid = 1'b0;
        end
        n = 0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            sync(1);
            n++;
        end
        cmp("response wait", 16'h0000, data_t'(n >= 400));
        cmp("wire address", data_t'(a), data_t'(sniff[25:17]));
        cmp("wire type", data_t'(w), data_t'(sniff[16]));
        if (w) begin
            mem[0][a] = int'(d);
            cmp("wire data", d, sniff[15:0]);
            cmp("pending writes", 16'h0000, data_t'(exp_q[0].size()));
        end else begin
            cmp("read data", data_t'(mem[0][a]), rsp_rdata);
            cmp("wire read", data_t'(mem[0][a]), msniff);
        end
    endtask

    // bench-driven frame on the second link, sck only inside the frame
    task automatic frame2(input logic [25:0] f, input int n,
                          output data_t rd);
        rd = 16'h0000;
        lk2.cs_b = 1'b0;
        #6;
        for (int i = 0; i < n; i++) begin
            lk2.mosi = f[25 - i];
            #3 lk2.sck = 1'b1;
            #3 lk2.sck = 1'b0;
            if (i >= 10)
                rd = {rd[14:0], lk2.miso};
        end
        #6 lk2.cs_b = 1'b1;
        lk2.mosi = ~lk2.mosi;
        #12;
        cmp("link release", 16'h0000, data_t'(lk2.miso_oe));
        sync(1);
    endtask

    task automatic stop_test;
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        data_t r;
        addr_t a;
        logic w;
        rst_b = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 9'h000;
        req_wdata = 16'h0000;
        rd_addr[0] = 9'h000;
        rd_addr[1] = 9'h000;
        lk2.sck = 1'b0;
        lk2.cs_b = 1'b1;
        lk2.mosi = 1'b0;
        fail_count = 0;
        checked = 0;
        // drop reset after time zero so every async reset sees the edge
        #1 rst_b = 1'b0;
        sync(10);
        rst_b = 1'b1;
        void'($urandom(32'h03D1));
        access(1'b0, 9'h1FF, 16'h0000, 1'b0);
        access(1'b1, 9'h000, 16'hFFFF, 1'b0);
        access(1'b1, 9'h1FF, 16'h8001, 1'b1);
        access(1'b0, 9'h1FF, 16'h0000, 1'b0);
        core_rd(0, 9'h1FF);
        for (int i = 0; i < 24; i++) begin
            w = 1'($urandom_range(0, 1));
            a = addr_t'($urandom_range(0, 7));
            access(w, a, data_t'($urandom), 1'b0);
            core_rd(0, a);
        end
        frame2({9'h033, 1'b1, 16'h1234}, 20, r);
        sync(6);
        core_rd(1, 9'h033);
        exp_q[1].push_back({9'h033, 16'h1234});
        mem[1][9'h033] = 32'h0000_1234;
        frame2({9'h033, 1'b1, 16'h1234}, 26, r);
        sync(6);
        core_rd(1, 9'h033);
        frame2({9'h033, 1'b0, 16'h0000}, 26, r);
        cmp("link read", 16'h1234, r);
        stop_test;
    end

    // hang guard, well beyond the expected run length
    initial begin
        #500000;
        fail_count++;
        stop_test;
    end
endmodule

`default_nettype wire
